// ### core/acs_cfg.svh
/*
 Constants of the acceleration sensor SPI command and error block:
 command and response bit positions, register addresses, control bit
 layout, error detail flags and initialisation timing.
 Assumes inclusion by bare name from the design files.
*/
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

`define ACS_FRAME_BITS 16
`define ACS_CNT_W 5
`define ACS_EDGES_PER_FRAME 5'h10
`define ACS_BIT_B15 15
`define ACS_BIT_B14 14
`define ACS_BIT_ACC 13

`define ACS_ADDR_CTL 5'h0E
`define ACS_ADDR_STAT 5'h10

`define ACS_CTL_CE 7
`define ACS_CTL_OFFSET_MONITOR_ENABLE 3
`define ACS_CTL_HIGHPASS_BYPASS_BIT 2
`define ACS_CTL_ST1 1
`define ACS_CTL_ST0 0
`define ACS_CTL_RST 8'h00
`define ACS_CTL_RD_MASK 8'h07

`define ACS_ST_ACC 2'h1
`define ACS_ST_SELF 2'h2
`define ACS_ST_ERR 2'h3

`define ACS_DET_SPI 10'h100
`define ACS_DET_REQ 10'h080
`define ACS_DET_ND 10'h010
`define ACS_DET_HE 10'h008
`define ACS_DET_CNC 10'h004

`define ACS_CLK_MHZ 20
`define ACS_P1_US 500
`define ACS_INIT_MS 3
`define ACS_HPF_MS 200
`define ACS_INIT_W 23

`endif

// ### core/acs_pkg.sv
/*
 Types of the acceleration sensor SPI command and error block.
 Assumes nothing of its surroundings.
*/
package acs_pkg;

  typedef enum logic [1:0] {
    acs_boot,
    acs_warmup,
    acs_ready
  } acs_init_t;

endpackage : acs_pkg

// ### core/acs_spi_core.sv
/*
 SPI slave command decoder, response builder and error classifier of a
 two-axis acceleration sensor. Each frame of 16 bits is decoded after
 chip select negates and its answer is shifted out in the next frame.
 Assumes: i_sclk is the master's serial clock, idle low, still while
 chip select is high; chip select stays high at least 6 i_clock cycles
 between frames; fault and data inputs are on i_clock.
// Function
// - Acceleration request during initialisation sets no-data bit 4
// - First acceleration request after initialisation gives no-data
// - Over-temperature, offset or parity give hardware fault
// - Oscillator fault needs running oscillator and compare failure
// - Bit 15 set gives conditions-not-correct plus faults
// - Bits 15:14 select unused, write, read, test
// - Non-acceleration answers report only oscillator, SPI, request
// - Only control register writable, else request error
// - Write answer shows bypass and self-test bits
// - Read takes address 12:8, returns data 7:0
// - Device test returns status register in 7:0
// - Status bit 0 set until clear-error write
// - Non-acceleration command with 15:14 zero is request error
// - Clock high at edges or edge count not 16
// - Phase one ignores SPI; phase two no-data only
// - Initialisation 3 ms, plus 200 ms with filter
// - Reset flag cleared only by clear-error after initialisation
// - Clear-error clears transient flags, persistent ones return
// - External errors reported once only
// - Only highest priority error, critical ones first
// - Oscillator fault drives data out high while selected
// - Clock idle low, sample leading edge, MSB first
// - Answer to each command comes in next frame
// - Response bits 11:10 give status, 9:0 error detail
*/
`timescale 1ns/1ps
`include "acs_cfg.svh"

module acs_spi_core #(
  parameter int unsigned P1_CYC = `ACS_P1_US * `ACS_CLK_MHZ,
  parameter int unsigned INIT_CYC = `ACS_INIT_MS * 1000 * `ACS_CLK_MHZ,
  parameter int unsigned HPF_CYC = `ACS_HPF_MS * 1000 * `ACS_CLK_MHZ
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_din,
  output logic o_dout,
  output logic o_dout_oe_n,
  input wire logic [9:0] i_accel_x,
  input wire logic [9:0] i_accel_y,
  input wire logic i_over_temp,
  input wire logic i_offset_err_x,
  input wire logic i_offset_err_y,
  input wire logic i_parity_err,
  input wire logic i_osc_running,
  input wire logic i_osc_cmp_fail,
  input wire logic i_hpf_present,
  output logic [4:0] o_reg_raddr,
  input wire logic [7:0] i_reg_rdata,
  output logic o_highpass_bypass_bit,
  output logic o_selftest_bit_hi,
  output logic o_selftest_bit_lo,
  output logic o_offset_monitor_enable,
  output logic o_clear_err,
  output logic [7:0] o_device_status_reg,
  output acs_pkg::acs_init_t o_init_state
);
  import acs_pkg::*;

  localparam logic [`ACS_INIT_W-1:0] P1_END = `ACS_INIT_W'(P1_CYC - 1);
  localparam logic [`ACS_INIT_W-1:0] INIT_END = `ACS_INIT_W'(INIT_CYC - 1);
  localparam logic [`ACS_INIT_W-1:0] HPF_END =
    `ACS_INIT_W'(INIT_CYC + HPF_CYC - 1);

  // Answer frame with odd parity in bit 12
  function automatic logic [15:0] acs_frame(
    input logic [2:0] top,
    input logic [1:0] st,
    input logic [9:0] body
  );
    logic [15:0] f;
    f = {top, 1'b0, st, body};
    f[12] = ~^f;
    return f;
  endfunction : acs_frame

  // ---------------- Link side, on the serial clock ----------------
  logic lk_clr;
  logic [`ACS_CNT_W-1:0] lk_cnt_q;
  logic [14:0] lk_sh_q;
  logic [15:0] lk_rx_q;
  logic [`ACS_CNT_W-1:0] lk_edges_q;
  logic lk_tog_q;
  logic [3:0] lk_idx_q;
  logic [15:0] tx_q;
  logic phase1;
  logic osc_fault;

  assign lk_clr = i_cs_n | ~i_rst_n;

  // Sample on the leading edge, MSB first
  always_ff @(posedge i_sclk or posedge lk_clr) begin
    if (lk_clr) begin
      lk_cnt_q <= '0;
      lk_sh_q <= '0;
    end else begin
      lk_sh_q <= {lk_sh_q[13:0], i_din};
      if (lk_cnt_q != '1) begin
        lk_cnt_q <= lk_cnt_q + `ACS_CNT_W'(1);
      end
    end
  end

  // Last word, edge total and frame marker survive the deselect
  always_ff @(posedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lk_rx_q <= '0;
      lk_edges_q <= '0;
      lk_tog_q <= 1'b0;
    end else if (!i_cs_n) begin
      lk_rx_q <= {lk_sh_q, i_din};
      lk_edges_q <= (lk_cnt_q == '1) ? lk_cnt_q : lk_cnt_q + `ACS_CNT_W'(1);
      if (lk_cnt_q == '0) begin
        lk_tog_q <= ~lk_tog_q;
      end
    end
  end

  // Shift out on the trailing edge
  always_ff @(negedge i_sclk or posedge lk_clr) begin
    if (lk_clr) begin
      lk_idx_q <= '0;
    end else if (lk_idx_q != 4'hF) begin
      lk_idx_q <= lk_idx_q + 4'h1;
    end
  end

  // Clock level at both chip select edges, stable until the frame is judged
  logic lk_hi_start_q;
  logic lk_hi_end_q;

  always_ff @(negedge i_cs_n or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lk_hi_start_q <= 1'b0;
    end else begin
      lk_hi_start_q <= i_sclk;
    end
  end

  always_ff @(posedge i_cs_n or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lk_hi_end_q <= 1'b0;
    end else begin
      lk_hi_end_q <= i_sclk;
    end
  end

  assign o_dout = osc_fault | tx_q[4'hF - lk_idx_q];
  assign o_dout_oe_n = i_cs_n | phase1;

  // ---------------- Synchronisers into i_clock ----------------
  logic [1:0] sy_in;
  logic [1:0] lvl_q;

  assign sy_in = {lk_tog_q, i_cs_n};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      logic sy1_q;
      logic sy2_q;
      logic sy3_q;
      logic lvl_bit_q;

      always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          sy1_q <= (g == 0);
          sy2_q <= (g == 0);
          sy3_q <= (g == 0);
          lvl_bit_q <= (g == 0);
        end else begin
          sy1_q <= sy_in[g];
          sy2_q <= sy1_q;
          sy3_q <= sy2_q;
          if (sy2_q == sy3_q) begin
            lvl_bit_q <= sy3_q;
          end
        end
      end

      assign lvl_q[g] = lvl_bit_q;
    end
  endgenerate

  logic cs_n_lvl;
  logic cs_n_prev_q;
  logic frame_end;
  logic tog_seen_q;

  assign cs_n_lvl = lvl_q[0];
  assign frame_end = ~cs_n_prev_q & cs_n_lvl;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_n_prev_q <= 1'b1;
      tog_seen_q <= 1'b0;
    end else begin
      cs_n_prev_q <= cs_n_lvl;
      if (frame_end) begin
        tog_seen_q <= lvl_q[1];
      end
    end
  end

  // ---------------- Initialisation sequence ----------------
  acs_init_t init_q;
  logic [`ACS_INIT_W-1:0] init_cnt_q;
  logic [`ACS_INIT_W-1:0] init_end;

  assign init_end = i_hpf_present ? HPF_END : INIT_END;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      init_q <= acs_boot;
      init_cnt_q <= '0;
    end else begin
      if (init_q != acs_ready) begin
        init_cnt_q <= init_cnt_q + `ACS_INIT_W'(1);
      end
      unique case (init_q)
        acs_boot: begin
          if (init_cnt_q == P1_END) begin
            init_q <= acs_warmup;
          end
        end
        acs_warmup: begin
          if (init_cnt_q >= init_end) begin
            init_q <= acs_ready;
          end
        end
        acs_ready: begin
          init_q <= acs_ready;
        end
      endcase
    end
  end

  assign phase1 = (init_q == acs_boot);
  assign o_init_state = init_q;

  // ---------------- Frame capture and evaluation ----------------
  logic eval_q;
  logic spi_err_q;
  logic [15:0] cmd_q;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      eval_q <= 1'b0;
      spi_err_q <= 1'b0;
      cmd_q <= 16'h0000;
    end else begin
      eval_q <= frame_end & ~phase1;
      if (frame_end) begin
        cmd_q <= lk_rx_q;
        spi_err_q <= lk_hi_start_q | lk_hi_end_q
          | (lvl_q[1] == tog_seen_q)
          | (lk_edges_q != `ACS_EDGES_PER_FRAME);
      end
    end
  end

  assign o_reg_raddr = cmd_q[12:8];

  // ---------------- Control and status ----------------
  logic [7:0] ctl_q;
  logic ctl_wr;
  logic ce;
  logic temp_q;
  logic offx_q;
  logic offy_q;
  logic ide_q;
  logic rstf_q;
  logic first_nd_q;
  logic acc_done;
  logic he;
  logic nd;

  assign ce = ctl_wr & cmd_q[`ACS_CTL_CE];
  assign o_clear_err = ce;
  assign osc_fault = i_osc_running & i_osc_cmp_fail;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctl_q <= `ACS_CTL_RST;
    end else if (ctl_wr) begin
      ctl_q <= cmd_q[7:0] & `ACS_CTL_RD_MASK | (cmd_q[7:0] & 8'h08);
    end
  end

  // Set wins over clear on every sticky flag
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      temp_q <= 1'b0;
      offx_q <= 1'b0;
      offy_q <= 1'b0;
      ide_q <= 1'b0;
    end else begin
      temp_q <= i_over_temp | (temp_q & ~ce);
      offx_q <= (i_offset_err_x & ctl_q[`ACS_CTL_OFFSET_MONITOR_ENABLE]) | (offx_q & ~ce);
      offy_q <= (i_offset_err_y & ctl_q[`ACS_CTL_OFFSET_MONITOR_ENABLE]) | (offy_q & ~ce);
      ide_q <= ide_q | i_parity_err;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rstf_q <= 1'b1;
    end else if (ce && init_q == acs_ready) begin
      rstf_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      first_nd_q <= 1'b1;
    end else if (acc_done && init_q == acs_ready) begin
      first_nd_q <= 1'b0;
    end
  end

  assign o_device_status_reg = {ide_q, osc_fault, init_q != acs_ready, temp_q,
                                i_hpf_present, offy_q, offx_q, rstf_q};
  assign o_highpass_bypass_bit = ctl_q[`ACS_CTL_HIGHPASS_BYPASS_BIT];
  assign o_selftest_bit_hi = ctl_q[`ACS_CTL_ST1];
  assign o_selftest_bit_lo = ctl_q[`ACS_CTL_ST0];
  assign o_offset_monitor_enable = ctl_q[`ACS_CTL_OFFSET_MONITOR_ENABLE];

  assign he = temp_q | offx_q | offy_q | ide_q;
  assign nd = (init_q != acs_ready) | first_nd_q;

  // ---------------- Response builder ----------------
  logic [15:0] resp_d;
  logic [9:0] det;
  logic [2:0] acc_top;
  logic [9:0] acc_val;

  assign acc_top = {1'b0, cmd_q[`ACS_BIT_B14], 1'b1};
  assign acc_val = cmd_q[`ACS_BIT_B14] ? i_accel_y : i_accel_x;

  always_comb begin
    resp_d = tx_q;
    ctl_wr = 1'b0;
    acc_done = 1'b0;
    det = 10'h000;
    if (eval_q) begin
      if (spi_err_q) begin
        resp_d = acs_frame(3'b000, `ACS_ST_ERR, `ACS_DET_SPI);
      end else if (cmd_q[`ACS_BIT_ACC]) begin
        acc_done = 1'b1;
        if (cmd_q[`ACS_BIT_B15]) begin
          det = `ACS_DET_CNC | (nd ? `ACS_DET_ND : 10'h000)
              | (he ? `ACS_DET_HE : 10'h000);
        end else if (he) begin
          det = `ACS_DET_HE;
        end else if (nd) begin
          det = `ACS_DET_ND;
        end
        if (det != 10'h000) begin
          resp_d = acs_frame(acc_top, `ACS_ST_ERR, det);
        end else if (ctl_q[`ACS_CTL_ST1] | ctl_q[`ACS_CTL_ST0]) begin
          resp_d = acs_frame(acc_top, `ACS_ST_SELF, acc_val);
        end else begin
          resp_d = acs_frame(acc_top, `ACS_ST_ACC, acc_val);
        end
      end else begin
        unique case (cmd_q[15:14])
          2'b00: begin
            resp_d = acs_frame(3'b000, `ACS_ST_ERR, `ACS_DET_REQ);
          end
          2'b01: begin
            if (cmd_q[12:8] == `ACS_ADDR_CTL) begin
              ctl_wr = 1'b1;
              resp_d = {cmd_q[15:8], cmd_q[7:0] & `ACS_CTL_RD_MASK};
            end else begin
              resp_d = acs_frame(3'b000, `ACS_ST_ERR, `ACS_DET_REQ);
            end
          end
          2'b10: begin
            if (cmd_q[12:8] == `ACS_ADDR_CTL) begin
              resp_d = {cmd_q[15:8], ctl_q & `ACS_CTL_RD_MASK};
            end else if (cmd_q[12:8] == `ACS_ADDR_STAT) begin
              resp_d = {cmd_q[15:8], o_device_status_reg};
            end else begin
              resp_d = {cmd_q[15:8], i_reg_rdata};
            end
          end
          2'b11: begin
            resp_d = {cmd_q[15:8], o_device_status_reg};
          end
        endcase
      end
    end
  end

  logic init_done_q;

  // Each new frame replaces the previous answer, so external errors show once
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_q <= 16'h0000;
    end else if (!init_done_q) begin
      tx_q <= acs_frame(3'b000, `ACS_ST_ERR, `ACS_DET_REQ);
    end else if (eval_q) begin
      tx_q <= resp_d;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      init_done_q <= 1'b0;
    end else begin
      init_done_q <= 1'b1;
    end
  end

endmodule : acs_spi_core

// ### verification/acs_spi_core_monitor.sv
/*
 Checker for the sensor SPI block, attached by bind.
 Assumes the clock domain of i_clock and reset i_rst_n.
*/
`timescale 1ns/1ps
module acs_spi_core_monitor #(
  parameter int unsigned P1_CYC = 20,
  parameter int unsigned INIT_CYC = 80,
  parameter int unsigned HPF_CYC = 100
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_cs_n,
  input wire logic i_osc_running,
  input wire logic i_osc_cmp_fail,
  input wire logic o_dout,
  input wire logic o_dout_oe_n,
  input wire logic o_clear_err,
  input wire logic o_highpass_bypass_bit,
  input wire logic o_selftest_bit_hi,
  input wire logic o_selftest_bit_lo,
  input wire logic [7:0] o_device_status_reg,
  input wire acs_pkg::acs_init_t o_init_state
);
  import acs_pkg::*;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  logic [15:0] cnt_q;
  logic osc_f;
  assign osc_f = i_osc_running && i_osc_cmp_fail;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) cnt_q <= 16'h0000;
    else if (cnt_q != 16'hFFFF) cnt_q <= cnt_q + 16'h0001;
  end
  oe_gate_a: assert property (o_dout_oe_n == !(!i_cs_n && o_init_state != acs_boot))
    else $error("output enable wrong");
  boot_len_a: assert property (cnt_q < P1_CYC - 1 |-> o_init_state == acs_boot)
    else $error("phase one ended early");
  warm_start_a: assert property (cnt_q > P1_CYC + 1 |-> o_init_state != acs_boot)
    else $error("phase one too long");
  init_len_a: assert property (cnt_q < INIT_CYC - 1 |-> o_init_state != acs_ready)
    else $error("init ended early");
  init_end_a: assert property (cnt_q > INIT_CYC + HPF_CYC + 2 |-> o_init_state == acs_ready)
    else $error("init too long");
  status_clr_a: assert property ($fell(o_device_status_reg[0])
    |-> ($past(o_clear_err) || o_clear_err) && o_init_state == acs_ready)
    else $error("reset flag cleared without clear-error");
  status_set_a: assert property (!$rose(o_device_status_reg[0]))
    else $error("reset flag set outside reset");
  osc_dout_a: assert property ((osc_f && !i_cs_n) [*4] |-> o_dout)
    else $error("data out not high on oscillator fault");
  osc_flag_a: assert property ((!i_osc_running) [*4] |-> !o_device_status_reg[6])
    else $error("oscillator fault with stopped oscillator");
  clr_pulse_a: assert property (o_clear_err |=> !o_clear_err)
    else $error("clear-error not a pulse");
  ctl_quiet_a: assert property (!$stable({o_highpass_bypass_bit, o_selftest_bit_hi,
    o_selftest_bit_lo}) |-> i_cs_n && $past(i_cs_n, 2))
    else $error("control bits changed inside a frame");
  cover property (o_clear_err);
  cover property (o_init_state == acs_ready);
  cover property (osc_f && !i_cs_n && o_dout);
endmodule : acs_spi_core_monitor

bind acs_spi_core acs_spi_core_monitor #(.P1_CYC(P1_CYC), .INIT_CYC(INIT_CYC),
  .HPF_CYC(HPF_CYC)) u_mon (.*);

// ### verification/acs_spi_core_tb_top.sv
/*
 Self-checking bench for the sensor SPI block with a master model.
 Assumes shortened init counts; each frame returns the previous answer.
*/
`timescale 1ns/1ps
module acs_spi_core_tb_top;
  import acs_pkg::*;
  logic i_clock, i_rst_n, sclk, cs_n, din, dout, oe_n, over_temp, osc_run;
  logic off_x, off_y, par_err, cmp_fail, offset_monitor_enable;
  logic [4:0] raddr;
  logic [7:0] rdata;
  acs_init_t init_st;
  int bad_count, checks;
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  acs_spi_master u_m (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(dout), .i_oe_n(oe_n));
  acs_spi_core #(.P1_CYC(20), .INIT_CYC(80), .HPF_CYC(100)) u_dut (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din),
    .o_dout(dout), .o_dout_oe_n(oe_n), .i_accel_x(10'h155), .i_accel_y(10'h2AA),
    .i_over_temp(over_temp), .i_offset_err_x(off_x), .i_offset_err_y(off_y),
    .i_parity_err(par_err), .i_osc_running(osc_run), .i_osc_cmp_fail(cmp_fail),
    .i_hpf_present(1'b0), .o_reg_raddr(raddr), .i_reg_rdata(rdata), .o_highpass_bypass_bit(),
    .o_selftest_bit_hi(), .o_selftest_bit_lo(), .o_offset_monitor_enable(offset_monitor_enable), .o_clear_err(),
    .o_device_status_reg(), .o_init_state(init_st));
  task stop_test;
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task frame(input logic [15:0] cmd, input logic [15:0] e);
    logic [15:0] r;
    u_m.xfer(cmd, 16, r);
    checks++;
    if (r !== e) begin
      bad_count++;
      $display("mismatch frame %h exp %h got %h", cmd, e, r);
    end
  endtask : frame
  task wait_state(input acs_init_t s);
    int i;
    for (i = 0; i < 400 && init_st !== s; i++) @(negedge i_clock);
    if (i == 400) begin
      bad_count++;
      $display("mismatch init_state exp %0d got %0d", s, init_st);
      stop_test();
    end
  endtask : wait_state
  task sc_init;
    logic [15:0] r;
    u_m.xfer(16'h2000, 16, r);
    checks++;
    if (u_m.oe_low !== 1'b0) begin
      bad_count++;
      $display("mismatch oe_n exp 1 got 0");
    end
    wait_state(acs_warmup);
    frame(16'h2000, 16'h0C80);
    frame(16'hC000, 16'h3C10);
  endtask : sc_init
  task sc_status;
    wait_state(acs_ready);
    frame(16'h2000, 16'hC021);
    frame(16'h2000, 16'h3C10);
  endtask : sc_status
  task sc_regs;
    frame(16'h4E87, 16'h2555);
    frame(16'hC000, 16'h4E07);
    frame(16'h8500, 16'hC000);
    checks++;
    if (raddr !== 5'h05) begin
      bad_count++;
      $display("mismatch reg_raddr exp 05 got %h", raddr);
    end
    frame(16'h4F00, 16'h85A5);
    frame(16'h0000, 16'h0C80);
  endtask : sc_regs
  task sc_errors;
    logic [15:0] r;
    @(negedge i_clock) over_temp = 1'b1;
    frame(16'hA000, 16'h0C80);
    frame(16'h2000, 16'h2C0C);
    u_m.xfer(16'h2000, 15, r);
    frame(16'h2000, 16'h0D00);
    frame(16'h2000, 16'h3C08);
  endtask : sc_errors
  task sc_offset;
    @(negedge i_clock);
    over_temp = 1'b0;
    off_x = 1'b1;
    off_y = 1'b1;
    frame(16'h4E88, 16'h3C08);
    checks++;
    if (offset_monitor_enable !== 1'b1) begin
      bad_count++;
      $display("mismatch offset_monitor_enable exp 1 got %b", offset_monitor_enable);
    end
    frame(16'h2000, 16'h4E00);
    @(negedge i_clock);
    off_x = 1'b0;
    off_y = 1'b0;
    par_err = 1'b1;
    frame(16'hC000, 16'h3C08);
    frame(16'h2000, 16'hC086);
  endtask : sc_offset
  task sc_osc;
    @(negedge i_clock) osc_run = 1'b1;
    repeat (5) @(negedge i_clock);
    frame(16'h2000, 16'hFFFF);
  endtask : sc_osc
  initial begin
    bad_count = 0;
    checks = 0;
    i_rst_n = 1'b0;
    over_temp = 1'b0;
    osc_run = 1'b0;
    off_x = 1'b0;
    off_y = 1'b0;
    par_err = 1'b0;
    cmp_fail = 1'b1;
    rdata = 8'hA5;
    repeat (16) @(posedge i_clock);
    @(negedge i_clock) i_rst_n = 1'b1;
    repeat (2) @(negedge i_clock);
    sc_init();
    sc_status();
    sc_regs();
    sc_errors();
    sc_offset();
    sc_osc();
    stop_test();
  end
endmodule : acs_spi_core_tb_top

// ### verification/acs_spi_master.sv
/*
 Behavioural SPI master driving the sensor block, one frame per call.
 Assumes its own 500 ns idle time after each frame is enough for answers to be prepared.
*/
`timescale 1ns/1ps
module acs_spi_master (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_din,
  input wire logic i_dout,
  input wire logic i_oe_n
);
  logic oe_low;
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_din = 1'b0;
    oe_low = 1'b0;
  end
  // Clock stands low outside frames, MSB first, sample on rising edge
  task automatic xfer(input logic [15:0] cmd, input int n, output logic [15:0] resp);
    resp = 16'h0000;
    oe_low = 1'b0;
    o_cs_n = 1'b0;
    #3;
    for (int i = 0; i < n; i++) begin
      o_din = cmd[15-i];
      #3;
      o_sclk = 1'b1;
      resp = {resp[14:0], i_dout};
      oe_low = oe_low | !i_oe_n;
      #3;
      o_sclk = 1'b0;
    end
    #3;
    o_cs_n = 1'b1;
    // Released line shows the inverse of its last value
    o_din = ~o_din;
    #500;
  endtask : xfer
endmodule : acs_spi_master
